// ### shared/rurs_pkg.sv
// constants for the remap / usb reset-state register bank
// assumes an apb master on the system clock; reset causes arrive as one-cycle pulses
package rurs_pkg;
   localparam int unsigned N_IN_REMAP = 27;
   localparam int unsigned N_OUT_REMAP = 23;
   localparam int unsigned N_EP = 16;
   localparam int unsigned N_DSGP = 2;
   // register map, byte addresses (word aligned)
   localparam logic [11:0] OFS_IN_REMAP = 12'h000;
   localparam logic [11:0] OFS_OUT_REMAP = 12'h080;
   localparam logic [11:0] OFS_OUT_REMAP_SOLO = 12'h0dc;
   localparam logic [11:0] OFS_USB_CFG = 12'h100;
   localparam logic [11:0] OFS_USB_IE = 12'h104;
   localparam logic [11:0] OFS_USB_EIE = 12'h108;
   localparam logic [11:0] OFS_EP = 12'h140;
   localparam logic [11:0] OFS_DSGP = 12'h180;
   localparam logic [11:0] OFS_STATUS = 12'h200;
   localparam logic [11:0] OFS_TOS = 12'h204;
   localparam logic [11:0] OFS_STACK_POINTER_REG = 12'h208;
   localparam logic [11:0] OFS_PC = 12'h20c;
   localparam logic [11:0] OFS_IRQ_FLAGS = 12'h210;
   // reset values, implemented-bit masks, wake vectors and unmapped read data
   localparam logic [7:0] RST_IN_REMAP = 8'hff;
   localparam logic [7:0] RST_OUT_REMAP = 8'h00;
   localparam logic [7:0] MASK_OUT_SOLO = 8'h0f;
   localparam logic [7:0] MASK_USB_CFG = 8'hd7;
   localparam logic [7:0] MASK_USB_IE = 8'h7f;
   localparam logic [7:0] MASK_USB_EIE = 8'h3f;
   localparam logic [7:0] MASK_EP = 8'h1f;
   localparam logic [7:0] MASK_SMALL_PKG = 8'h3f;
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW = 21'h000018;
   localparam logic [4:0] STACK_POINTER_REG_RST = 5'h00;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   typedef enum logic [3:0] {
      RURS_EV_NONE = 4'b0001,
      RURS_EV_POR = 4'b0010,
      RURS_EV_HARD = 4'b0100,
      RURS_EV_WAKE = 4'b1000
   } rurs_ev_t;
endpackage

// ### hw/rurs_cause.sv
// reset-cause priority decoder
// assumes cause inputs are synchronous pulses from the reset controller
`timescale 1ns/1ps
module rurs_cause (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_por,
   input wire logic i_bor,
   input wire logic i_master_clear_pin,
   input wire logic i_wdt_rst,
   input wire logic i_instr_rst,
   input wire logic i_stack_rst,
   input wire logic i_wake,
   output rurs_pkg::rurs_ev_t o_ev
);
   import rurs_pkg::*;
   wire any_por;
   wire any_hard;
   rurs_ev_t ev_nxt;
   // power-on wins over other resets, any reset over a wake
   assign any_por = i_por | i_bor;
   assign any_hard = i_master_clear_pin | i_wdt_rst | i_instr_rst | i_stack_rst;
   assign ev_nxt = any_por ? RURS_EV_POR :
                   any_hard ? RURS_EV_HARD :
                   i_wake ? RURS_EV_WAKE : RURS_EV_NONE;
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ev <= RURS_EV_NONE;
      end else begin
         o_ev <= ev_nxt;
      end
   end
endmodule

// ### hw/rurs_top.sv
// remap and usb register bank with reset-state and wake-up handling
// assumes apb master on i_clk_sys; core inputs are on the same clock
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rurs_top #(
   parameter bit SMALL_PKG = 1'b0
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_por,
   input wire logic i_bor,
   input wire logic i_master_clear_pin,
   input wire logic i_wdt_rst,
   input wire logic i_instr_rst,
   input wire logic i_stack_rst,
   input wire logic i_wake,
   input wire logic i_wake_irq,
   input wire logic i_wake_hi,
   input wire logic [7:0] i_wake_src,
   input wire logic i_gie_low,
   input wire logic i_gie_high,
   input wire logic i_vbat_ok,
   input wire logic [20:0] i_pc,
   output logic [20:0] o_pc,
   output logic o_pc_load,
   output logic [20:0] o_tos,
   output logic [4:0] o_stack_pointer_reg,
   output logic [7:0] o_irq_flags
);
   import rurs_pkg::*;
   rurs_ev_t ev;
   logic [7:0] in_remap_r [N_IN_REMAP];
   logic [7:0] out_remap_r [N_OUT_REMAP];
   logic [7:0] out_solo_r;
   logic [7:0] usb_cfg_r;
   logic [7:0] usb_ie_r;
   logic [7:0] usb_eie_r;
   logic [7:0] ep_r [N_EP];
   logic [7:0] dsgp_r [N_DSGP];
   logic dsgp_valid_r;
   logic [20:0] pc_r;
   logic pc_load_r;
   logic [20:0] tos_r;
   logic [4:0] stack_pointer_reg_r;
   logic [7:0] flags_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic wake_irq_p;
   logic wake_hold;
   logic [7:0] wake_src_p;

   function automatic logic [7:0] pkg_mask(input logic [7:0] m);
      // marked registers lose their top two bits on small packages
      pkg_mask = SMALL_PKG ? (m & MASK_SMALL_PKG) : m;
   endfunction

   function automatic logic in_win(input logic [11:0] a, input logic [11:0] base,
                                   input int unsigned n);
      in_win = (a >= base) && (a < 12'(base + 12'(n * 4))) && (a[1:0] == 2'b00);
   endfunction

   wire is_rst = (ev == RURS_EV_POR) || (ev == RURS_EV_HARD);
   wire is_por = (ev == RURS_EV_POR);
   wire is_wake = (ev == RURS_EV_WAKE);
   wire gie_any = i_gie_low | i_gie_high;
   wire wake_push = is_wake && wake_irq_p && gie_any;
   wire setup = i_psel && !i_penable;
   wire wr_en = i_psel && i_penable && i_pwrite && pready_r;
   wire [9:0] widx = i_paddr[11:2];
   wire hit_in = in_win(i_paddr, OFS_IN_REMAP, N_IN_REMAP);
   wire hit_out = in_win(i_paddr, OFS_OUT_REMAP, N_OUT_REMAP);
   wire hit_ep = in_win(i_paddr, OFS_EP, N_EP);
   wire hit_dsgp = in_win(i_paddr, OFS_DSGP, N_DSGP);
   wire [4:0] i_in = 5'(widx - 10'(OFS_IN_REMAP >> 2));
   wire [4:0] i_out = 5'(widx - 10'(OFS_OUT_REMAP >> 2));
   wire [3:0] i_ep = 4'(widx - 10'(OFS_EP >> 2));
   wire [0:0] i_ds = 1'(widx - 10'(OFS_DSGP >> 2));
   wire [7:0] wbyte = i_pwdata[7:0];
   wire mapped = hit_in || hit_out || hit_ep || hit_dsgp ||
                 i_paddr == OFS_OUT_REMAP_SOLO || i_paddr == OFS_USB_CFG ||
                 i_paddr == OFS_USB_IE || i_paddr == OFS_USB_EIE ||
                 i_paddr == OFS_STATUS || i_paddr == OFS_TOS ||
                 i_paddr == OFS_STACK_POINTER_REG || i_paddr == OFS_PC ||
                 i_paddr == OFS_IRQ_FLAGS;
   logic [31:0] rd_mux;

   rurs_cause u_cause (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_por(i_por),
      .i_bor(i_bor),
      .i_master_clear_pin(i_master_clear_pin),
      .i_wdt_rst(i_wdt_rst),
      .i_instr_rst(i_instr_rst),
      .i_stack_rst(i_stack_rst),
      .i_wake(i_wake),
      .o_ev(ev)
   );

   // wake details are held one cycle to line up with the decoded event;
   // the source byte too, since it is gone by the time the event is decoded
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         wake_irq_p <= 1'b0;
         wake_hold <= 1'b0;
         wake_src_p <= 8'h00;
      end else begin
         wake_irq_p <= i_wake_irq;
         wake_hold <= i_wake_hi;
         wake_src_p <= i_wake_src;
      end
   end

   // remap selections: set on resets, untouched by wakes
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int k = 0; k < N_IN_REMAP; k++) in_remap_r[k] <= RST_IN_REMAP;
         for (int k = 0; k < N_OUT_REMAP; k++) out_remap_r[k] <= RST_OUT_REMAP;
         out_solo_r <= RST_OUT_REMAP;
      end else if (is_rst) begin
         for (int k = 0; k < N_IN_REMAP; k++) in_remap_r[k] <= RST_IN_REMAP;
         for (int k = 0; k < N_OUT_REMAP; k++) out_remap_r[k] <= RST_OUT_REMAP;
         out_solo_r <= RST_OUT_REMAP;
      end else if (wr_en) begin
         // a wake event falls through here with no reload
         if (hit_in) in_remap_r[i_in] <= wbyte;
         if (hit_out) out_remap_r[i_out] <= wbyte;
         if (i_paddr == OFS_OUT_REMAP_SOLO) out_solo_r <= wbyte & MASK_OUT_SOLO;
      end
   end

   // usb configuration, enables and endpoint controls
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         usb_cfg_r <= 8'h00;
         usb_ie_r <= 8'h00;
         usb_eie_r <= 8'h00;
         for (int k = 0; k < N_EP; k++) ep_r[k] <= 8'h00;
      end else if (is_rst) begin
         usb_cfg_r <= 8'h00;
         usb_ie_r <= 8'h00;
         usb_eie_r <= 8'h00;
         for (int k = 0; k < N_EP; k++) ep_r[k] <= 8'h00;
      end else if (wr_en) begin
         // unimplemented positions never store, so they read zero
         if (i_paddr == OFS_USB_CFG) usb_cfg_r <= wbyte & MASK_USB_CFG;
         if (i_paddr == OFS_USB_IE) usb_ie_r <= wbyte & MASK_USB_IE;
         if (i_paddr == OFS_USB_EIE) usb_eie_r <= wbyte & MASK_USB_EIE;
         if (hit_ep) ep_r[i_ep] <= wbyte & MASK_EP;
      end
   end

   // deep-sleep words clear on i_nrst, on the first power-on, or on the first power-on after battery was lost
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         dsgp_valid_r <= 1'b0;
         for (int k = 0; k < N_DSGP; k++) dsgp_r[k] <= 8'h00;
      end else if (!i_vbat_ok) begin
         dsgp_valid_r <= 1'b0;
      end else if (is_por && !dsgp_valid_r) begin
         dsgp_valid_r <= 1'b1;
         for (int k = 0; k < N_DSGP; k++) dsgp_r[k] <= 8'h00;
      end else if (wr_en && hit_dsgp) begin
         dsgp_r[i_ds] <= wbyte;
      end
   end

   // core side: stack push and vector load on interrupt wake
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pc_r <= 21'h0;
         pc_load_r <= 1'b0;
         tos_r <= 21'h0;
         stack_pointer_reg_r <= STACK_POINTER_REG_RST;
         flags_r <= 8'h00;
      end else if (is_rst) begin
         pc_load_r <= 1'b0;
         stack_pointer_reg_r <= STACK_POINTER_REG_RST;
      end else begin
         pc_load_r <= wake_push;
         if (wake_push) begin
            tos_r <= i_pc;
            stack_pointer_reg_r <= 5'(stack_pointer_reg_r + 5'd1);
            pc_r <= wake_hold ? VEC_HIGH : VEC_LOW;
         end
         // source flag set on wake wins over a software clear
         if (is_wake) begin
            flags_r <= ((wr_en && i_paddr == OFS_IRQ_FLAGS) ? (flags_r & ~wbyte) : flags_r)
                       | ((wake_src_p == 8'h00) ? 8'h01 : wake_src_p);
         end else if (wr_en && i_paddr == OFS_IRQ_FLAGS) begin
            flags_r <= flags_r & ~wbyte;
         end
      end
   end

   always_comb begin
      rd_mux = UNMAPPED_DATA;
      if (hit_in) rd_mux = {24'h0, pkg_mask(in_remap_r[i_in])};
      else if (hit_out) rd_mux = {24'h0, pkg_mask(out_remap_r[i_out])};
      else if (hit_ep) rd_mux = {24'h0, ep_r[i_ep]};
      else if (hit_dsgp) rd_mux = {24'h0, dsgp_r[i_ds]};
      else if (i_paddr == OFS_OUT_REMAP_SOLO) rd_mux = {24'h0, out_solo_r};
      else if (i_paddr == OFS_USB_CFG) rd_mux = {24'h0, usb_cfg_r};
      else if (i_paddr == OFS_USB_IE) rd_mux = {24'h0, usb_ie_r};
      else if (i_paddr == OFS_USB_EIE) rd_mux = {24'h0, usb_eie_r};
      else if (i_paddr == OFS_STATUS) rd_mux = {28'h0, ev};
      else if (i_paddr == OFS_TOS) rd_mux = {11'h0, tos_r};
      else if (i_paddr == OFS_STACK_POINTER_REG) rd_mux = {27'h0, stack_pointer_reg_r};
      else if (i_paddr == OFS_PC) rd_mux = {11'h0, pc_r};
      else if (i_paddr == OFS_IRQ_FLAGS) rd_mux = {24'h0, flags_r};
   end

   // no wait states: pready rises in the first access cycle
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && !mapped;
         if (setup && !i_pwrite) prdata_r <= rd_mux;
      end
   end

   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_pc = pc_r;
   assign o_pc_load = pc_load_r;
   assign o_tos = tos_r;
   assign o_stack_pointer_reg = stack_pointer_reg_r;
   assign o_irq_flags = flags_r;

   AST_PUSH_PTR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      wake_push |=> (o_stack_pointer_reg == 5'($past(o_stack_pointer_reg) + 5'd1)) && o_tos == $past(i_pc))
      else $error("stack push on wake wrong");
   AST_VECTOR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      wake_push |=> o_pc_load && (o_pc == VEC_HIGH || o_pc == VEC_LOW))
      else $error("vector not loaded");
   AST_FLAG: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      is_wake |=> o_irq_flags != 8'h00 && (o_irq_flags & $past(wake_src_p)) == $past(wake_src_p))
      else $error("no wake source flag");
   AST_CFG_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (usb_cfg_r & ~MASK_USB_CFG) == 8'h00 && (usb_ie_r & ~MASK_USB_IE) == 8'h00)
      else $error("unimplemented bit set");
   AST_DSGP_KEEP: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (is_por && dsgp_valid_r && i_vbat_ok) |=> dsgp_r[0] == $past(dsgp_r[0]))
      else $error("deep-sleep word lost");
   AST_IN_ONES: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      is_rst |=> in_remap_r[0] == RST_IN_REMAP && in_remap_r[N_IN_REMAP-1] == RST_IN_REMAP)
      else $error("input remap not ones");
   AST_OUT_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      is_rst |=> out_remap_r[0] == 8'h00 && out_solo_r == 8'h00)
      else $error("output remap not zero");
   AST_USB_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      is_rst |=> usb_cfg_r == 8'h00 && usb_ie_r == 8'h00 && usb_eie_r == 8'h00)
      else $error("usb regs not cleared");
   AST_EP_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      is_rst |=> ep_r[0] == 8'h00 && ep_r[N_EP-1] == 8'h00)
      else $error("endpoint not cleared");
   AST_WAKE_KEEP: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (is_wake && !wr_en) |=> $stable(usb_cfg_r) && $stable(in_remap_r[0]))
      else $error("wake changed register");
   AST_SP_RST: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      is_rst |=> o_stack_pointer_reg == STACK_POINTER_REG_RST)
      else $error("stack pointer not zero");
   AST_PRIO: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      (i_por && i_master_clear_pin && i_wake) |=> ev == RURS_EV_POR)
      else $error("reset priority wrong");
endmodule

// ### verif/tb_top.sv
// self-checking bench for the remap / usb reset-state register bank
// assumes rurs_pkg and rurs_top are compiled first; the bench drives apb and core pins itself
`timescale 1ns/1ps
module tb_top;
   import rurs_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] wd; logic [31:0] rd; logic err; logic sm;} rurs_row_t;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, prdata_s, rd_s;
   logic pready, pslverr, pc_load;
   logic wake = 1'b0, wirq = 1'b0, whi = 1'b0, gl = 1'b0, gh = 1'b0, vbat = 1'b1;
   logic [5:0] cause = 6'h00;
   logic [7:0] wsrc = 8'h00, flags;
   logic [20:0] pc_in = 21'h000000, pc_out, tos;
   logic [4:0] sp;
   int mismatches = 0;
   int tests_run = 0;
   rurs_row_t rows[11] = '{
      '{OFS_IN_REMAP, 32'hffff_ff5a, 32'h5a, 1'b0, 1'b1},
      '{12'h068, 32'h0000_00ff, 32'hff, 1'b0, 1'b1},
      '{OFS_OUT_REMAP, 32'h0000_00a5, 32'ha5, 1'b0, 1'b1},
      '{12'h0d8, 32'h0000_003c, 32'h3c, 1'b0, 1'b1},
      '{OFS_OUT_REMAP_SOLO, 32'h0000_00ff, {24'h0, MASK_OUT_SOLO}, 1'b0, 1'b1},
      '{OFS_USB_CFG, 32'hffff_ffff, {24'h0, MASK_USB_CFG}, 1'b0, 1'b0},
      '{OFS_USB_IE, 32'h0000_00ff, {24'h0, MASK_USB_IE}, 1'b0, 1'b0},
      '{OFS_USB_EIE, 32'h0000_00ff, {24'h0, MASK_USB_EIE}, 1'b0, 1'b0},
      '{OFS_EP, 32'h0000_00ff, {24'h0, MASK_EP}, 1'b0, 1'b0},
      '{12'h17c, 32'h0000_00ff, {24'h0, MASK_EP}, 1'b0, 1'b0},
      '{12'h300, 32'h0000_00ff, UNMAPPED_DATA, 1'b1, 1'b0}};

   rurs_top u_rurs_top (.i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_por(cause[0]), .i_bor(cause[1]), .i_master_clear_pin(cause[2]),
      .i_wdt_rst(cause[3]), .i_instr_rst(cause[4]), .i_stack_rst(cause[5]), .i_wake(wake),
      .i_wake_irq(wirq), .i_wake_hi(whi), .i_wake_src(wsrc), .i_gie_low(gl), .i_gie_high(gh),
      .i_vbat_ok(vbat), .i_pc(pc_in), .o_pc(pc_out), .o_pc_load(pc_load), .o_tos(tos),
      .o_stack_pointer_reg(sp), .o_irq_flags(flags));
   // the small-package variant shares every input; only its read data is compared
   rurs_top #(.SMALL_PKG(1'b1)) u_rurs_top_small (.i_clk_sys(clk), .i_nrst(nrst),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata_s), .o_pready(), .o_pslverr(), .i_por(cause[0]), .i_bor(cause[1]),
      .i_master_clear_pin(cause[2]), .i_wdt_rst(cause[3]), .i_instr_rst(cause[4]), .i_stack_rst(cause[5]),
      .i_wake(wake), .i_wake_irq(wirq), .i_wake_hi(whi), .i_wake_src(wsrc), .i_gie_low(gl),
      .i_gie_high(gh), .i_vbat_ok(vbat), .i_pc(pc_in), .o_pc(), .o_pc_load(), .o_tos(),
      .o_stack_pointer_reg(), .o_irq_flags());

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one idle edge after each transfer so no signal is assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      rd_s = prdata_s;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 16) chk("pready", 32'h1, 32'h0);
      @(posedge clk);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] exp_s);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      chk("read data", exp, d);
      chk("small read data", exp_s, rd_s);
   endtask

   task automatic pulse(input int k);
      cause <= 6'h01 << k;
      @(posedge clk);
      cause <= 6'h00;
      repeat (4) @(posedge clk);
   endtask

   // leaves the caller at the edge that samples the cycle in which results stand
   task automatic wake_ev(input logic irq, input logic hi, input logic [7:0] src);
      wake <= 1'b1;
      wirq <= irq;
      whi <= hi;
      wsrc <= src;
      @(posedge clk);
      wake <= 1'b0;
      wirq <= 1'b0;
      whi <= 1'b0;
      wsrc <= 8'h00;
      repeat (2) @(posedge clk);
   endtask

   task automatic sweep(input logic wr);
      logic [31:0] d, xs;
      logic e;
      foreach (rows[i]) begin
         xs = rows[i].sm ? (rows[i].rd & {24'h0, MASK_SMALL_PKG}) : rows[i].rd;
         if (wr) apb(1'b1, rows[i].a, rows[i].wd, d, e);
         if (wr) chk("slverr", {31'h0, rows[i].err}, {31'h0, e});
         rdc(rows[i].a, rows[i].rd, xs);
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end

   initial begin
      logic [31:0] d;
      logic e;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      pulse(0);
      chk("stack pointer", 32'h0, {27'h0, sp});
      sweep(1'b1);
      $display("test register table done");
      gh <= 1'b1;
      pc_in <= 21'h001234;
      wake_ev(1'b1, 1'b1, 8'h04);
      chk("pc load", 32'h1, {31'h0, pc_load});
      chk("vector high", {11'h0, VEC_HIGH}, {11'h0, pc_out});
      chk("tos", 32'h001234, {11'h0, tos});
      chk("stack pointer", 32'h1, {27'h0, sp});
      chk("flags", 32'h04, {24'h0, flags & 8'h04});
      gh <= 1'b0;
      gl <= 1'b1;
      pc_in <= 21'h0abcde;
      wake_ev(1'b1, 1'b0, 8'h00);
      chk("vector low", {11'h0, VEC_LOW}, {11'h0, pc_out});
      chk("tos", 32'h0abcde, {11'h0, tos});
      chk("stack pointer", 32'h2, {27'h0, sp});
      chk("flag zero", 32'h1, {31'h0, flags[0]});
      gl <= 1'b0;
      wake_ev(1'b1, 1'b1, 8'h02);
      chk("no gie load", 32'h0, {31'h0, pc_load});
      chk("no gie push", 32'h2, {27'h0, sp});
      gl <= 1'b1;
      wake_ev(1'b0, 1'b0, 8'h10);
      chk("watchdog wake load", 32'h0, {31'h0, pc_load});
      sweep(1'b0);
      apb(1'b1, OFS_IRQ_FLAGS, 32'h0000_00ff, d, e);
      rdc(OFS_IRQ_FLAGS, 32'h0, 32'h0);
      $display("test wake done");
      for (int k = 0; k < 6; k++) begin
         apb(1'b1, OFS_IN_REMAP, 32'h0000_0012, d, e);
         apb(1'b1, OFS_OUT_REMAP, 32'h0000_0034, d, e);
         apb(1'b1, OFS_USB_CFG, 32'h0000_0001, d, e);
         apb(1'b1, OFS_USB_IE, 32'h0000_0041, d, e);
         apb(1'b1, 12'h17c, 32'h0000_0011, d, e);
         wake_ev(1'b1, 1'b1, 8'h01);
         pulse(k);
         rdc(OFS_IN_REMAP, {24'h0, RST_IN_REMAP}, {24'h0, RST_IN_REMAP & MASK_SMALL_PKG});
         rdc(OFS_OUT_REMAP, {24'h0, RST_OUT_REMAP}, 32'h0);
         rdc(OFS_USB_CFG, 32'h0, 32'h0);
         rdc(OFS_USB_IE, 32'h0, 32'h0);
         rdc(12'h17c, 32'h0, 32'h0);
         chk("stack pointer", 32'h0, {27'h0, sp});
      end
      // power-on, master-clear and an interrupt wake all in one cycle: reset must win
      apb(1'b1, OFS_IN_REMAP, 32'h0000_0012, d, e);
      wirq <= 1'b1;
      wake <= 1'b1;
      cause <= 6'h05;
      @(posedge clk);
      wirq <= 1'b0;
      wake <= 1'b0;
      cause <= 6'h00;
      repeat (4) @(posedge clk);
      chk("no push under reset", 32'h0, {27'h0, sp});
      chk("no load under reset", 32'h0, {31'h0, pc_load});
      rdc(OFS_IN_REMAP, {24'h0, RST_IN_REMAP}, {24'h0, RST_IN_REMAP & MASK_SMALL_PKG});
      $display("test reset causes done");
      apb(1'b1, OFS_DSGP, 32'h0000_003c, d, e);
      pulse(0);
      rdc(OFS_DSGP, 32'h3c, 32'h3c);
      vbat <= 1'b0;
      @(posedge clk);
      vbat <= 1'b1;
      pulse(0);
      rdc(OFS_DSGP, 32'h0, 32'h0);
      $display("test deep sleep done");
      complete_run();
   end
endmodule
